// file: rtl/tws_if.sv
// two-wire bus between master end and slave end, open-drain resolved
interface tws_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // pulled-up wired-and; an end pulls low only when its enable is low
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
  modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n,
                  input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// file: rtl/tws_master.sv
// bus master end: makes the clock, START, STOP and byte framing
module tws_master (
  input wire logic ref_clk,
  input wire logic rst,
  tws_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [tws_pkg::SEL_W-1:0] cmd_addr,
  input wire logic [3:0] cmd_count,
  input wire logic [tws_pkg::BYTE_W-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [tws_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic done,
  output logic nack_err
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} tws_mst_t;
  localparam logic [7:0] QLAST = 8'(tws_pkg::SCL_QUARTER_CYC - 1);
  tws_mst_t state_reg, state_next;
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
  logic [7:0] q_reg, q_next, sh_reg, sh_next, rxd_reg, rxd_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next, rem_reg, rem_next;
  logic rd_reg, rd_next, first_reg, first_next, scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next, crdy_reg, crdy_next, wrdy_reg, wrdy_next;
  logic rxv_reg, rxv_next, done_reg, done_next, nerr_reg, nerr_next;
  logic tick, talk, idle_bus;
  logic [3:0] left;

  // three-stage synchronisers on the resolved lines
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
    end
  end

  assign tick = (q_reg == QLAST);
  assign idle_bus = scl_f_reg & sda_f_reg;
  assign talk = first_reg | ~rd_reg; // master sends this byte
  assign left = first_reg ? rem_reg : rem_reg - 4'h1;

  // quarter-period sequencer; four quarters per bit
  always_comb begin
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    state_next = state_reg;
    q_next = (state_reg == M_IDLE | tick) ? 8'h00 : q_reg + 8'h01;
    ph_next = ph_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rem_next = rem_reg;
    rd_next = rd_reg;
    first_next = first_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    crdy_next = 1'b0;
    wrdy_next = wrdy_reg;
    rxd_next = rxd_reg;
    rxv_next = 1'b0;
    done_next = 1'b0;
    nerr_next = nerr_reg;
    case (state_reg)
      M_IDLE: begin
        crdy_next = idle_bus & ~(cmd_valid & crdy_reg);
        if (cmd_valid & crdy_reg) begin
          sh_next = {tws_pkg::DEV_ID, cmd_addr, cmd_read};
          rem_next = cmd_count;
          rd_next = cmd_read;
          nerr_next = 1'b0;
          ph_next = 2'h0;
          state_next = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          if (ph_reg == 2'h0) begin
            sda_oe_next = 1'b0;
            ph_next = 2'h1;
          end else begin
            scl_oe_next = 1'b0;
            ph_next = 2'h0;
            bit_next = 4'h0;
            first_next = 1'b1;
            state_next = M_BIT;
          end
        end
      end
      M_BIT: begin
        if (wrdy_reg) begin
          // clock held low until the next write byte shows up
          if (wr_valid) begin
            wrdy_next = 1'b0;
            sh_next = wr_data;
            bit_next = 4'h0;
            ph_next = 2'h0;
          end
        end else if (tick) begin
          ph_next = ph_reg + 2'h1;
          case (ph_reg)
            2'h0: begin
              if (bit_reg != tws_pkg::ACK_BIT) begin
                sda_oe_next = talk ? sh_reg[7] : 1'b1;
              end else begin
                sda_oe_next = talk | (rem_reg == 4'h1);
              end
            end
            2'h1: begin
              scl_oe_next = 1'b1;
            end
            2'h2: begin
              if (bit_reg != tws_pkg::ACK_BIT) begin
                sh_next = {sh_reg[6:0], sda_f_reg};
              end else if (talk & sda_f_reg) begin
                nerr_next = 1'b1;
              end
            end
            default: begin
              scl_oe_next = 1'b0;
              if (bit_reg != tws_pkg::ACK_BIT) begin
                bit_next = bit_reg + 4'h1;
              end else begin
                if (~first_reg & rd_reg) begin
                  rxd_next = sh_reg;
                  rxv_next = 1'b1;
                end
                rem_next = left;
                first_next = 1'b0;
                if (nerr_reg | left == 4'h0) begin
                  ph_next = 2'h0;
                  state_next = M_STOP;
                end else if (~rd_reg) begin
                  wrdy_next = 1'b1;
                  ph_next = 2'h3;
                end else begin
                  bit_next = 4'h0;
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          if (ph_reg == 2'h0) begin
            sda_oe_next = 1'b0;
          end else if (ph_reg == 2'h1) begin
            scl_oe_next = 1'b1;
          end else begin
            sda_oe_next = 1'b1;
            done_next = 1'b1;
            state_next = M_IDLE;
          end
        end
      end
      default: begin
        state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      state_reg <= M_IDLE;
      q_reg <= 8'h00;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rem_reg <= 4'h0;
      rd_reg <= 1'b0;
      first_reg <= 1'b0;
      scl_oe_reg <= 1'b1;
      sda_oe_reg <= 1'b1;
      crdy_reg <= 1'b0;
      wrdy_reg <= 1'b0;
      rxd_reg <= 8'h00;
      rxv_reg <= 1'b0;
      done_reg <= 1'b0;
      nerr_reg <= 1'b0;
    end else begin
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      state_reg <= state_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      rem_reg <= rem_next;
      rd_reg <= rd_next;
      first_reg <= first_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      crdy_reg <= crdy_next;
      wrdy_reg <= wrdy_next;
      rxd_reg <= rxd_next;
      rxv_reg <= rxv_next;
      done_reg <= done_next;
      nerr_reg <= nerr_next;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe_n = scl_oe_reg;
  assign bus.m_sda_oe_n = sda_oe_reg;
  assign cmd_ready = crdy_reg;
  assign wr_ready = wrdy_reg;
  assign rx_data = rxd_reg;
  assign rx_valid = rxv_reg;
  assign done = done_reg;
  assign nack_err = nerr_reg;
endmodule // tws_master

// file: rtl/tws_pkg.sv
// shared constants of the two-wire slave port and its bus master
// Operation
// - bus idle when data and clock high
// - data falls while clock high: START
// - data rises while clock high: STOP
// - data changes only while clock low
// - eight-bit bytes plus ninth acknowledge bit
// - master decides byte count per transfer
// - works at standard and fast clock rates; the master meets fast only, at 100 its 8-bit quarter count wraps
// - acknowledger holds data low through ack-high
// - refuse every request during nonvolatile write; a read already past its address keeps sending
// - master nacks last read byte; slave releases
// - write: address then data, all acknowledged
// - read: slave sends bytes, master acks
// - transfer ends with STOP or repeated START
// - hardware address match picks receive/transmit
// - transmitter drives data, clock only input
// - first byte: identifier, device address, direction
// - master makes all clocks, START, STOP
// - slave data pin is open-drain only
// - device address from three select bits
// - address write commits nonvolatile, port busy
package tws_pkg;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 3;
  localparam int FIFO_DEPTH = 4;
  // fixed device identifier, value arbitrary
  localparam logic [3:0] DEV_ID = 4'hB;
  localparam logic [2:0] ADDR_SEL_RESET = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int CLK_PERIOD_NS = 4;
  // nonvolatile write time, least time so rounded up
  localparam int NV_WRITE_TIME_NS = 10000000;
  localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // master clock rate: 400 for fast; 100 overflows the 8-bit quarter count (113 cycles, not 625)
  localparam int SCL_FREQ_KHZ = 400;
  localparam int SCL_QUARTER_NS = 1000000 / (SCL_FREQ_KHZ * 4);
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: rtl/tws_slave.sv
// slave end of the two-wire port with transmit byte fifo
module tws_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [W-1:0] mem_next [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic room_reg, room_next, nempty_reg, nempty_next;
  logic push, pop;

  // pointer and count update; room and not-empty registered so ready leaves a flop
  always_comb begin
    push = in_valid & room_reg;
    pop = out_ready & nempty_reg;
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    room_next = (cnt_next != (AW + 1)'(D));
    nempty_next = (cnt_next != '0);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < D; i++) begin
        mem_reg[i] <= '0;
      end
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      room_reg <= 1'b1;
      nempty_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      room_reg <= room_next;
      nempty_reg <= nempty_next;
    end
  end

  assign in_ready = room_reg;
  assign out_valid = nempty_reg;
  assign out_data = mem_reg[rp_reg];
endmodule // tws_fifo

module tws_slave #(
  parameter int NV_CYCLES = tws_pkg::NV_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  tws_if.slave bus,
  input wire logic addr_wr,
  input wire logic [tws_pkg::SEL_W-1:0] addr_wr_data,
  input wire logic commit_to_nonvolatile_command,
  output logic [tws_pkg::SEL_W-1:0] addr_sel,
  output logic nv_busy,
  output logic [tws_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  input wire logic [tws_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_CHK, S_ADDR_ACK, S_RX, S_RX_END, S_RX_ACK, S_TX, S_TX_ACK, S_IGNORE
  } tws_sst_t;
  tws_sst_t state_reg, state_next;
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next, scl_d_reg, sda_d_reg;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, rxd_reg, rxd_next;
  logic oe_n_reg, oe_n_next, dir_reg, dir_next, mack_reg, mack_next;
  logic first_reg, first_next, rxv_reg, rxv_next, rxf_reg, rxf_next;
  logic [2:0] sel_reg, sel_next;
  logic [31:0] nv_cnt_reg, nv_cnt_next;
  logic busy_reg, busy_next;
  logic scl_rise, scl_fall, start_seen, stop_seen, pop, match;
  logic [7:0] fifo_data, load_byte;
  logic fifo_valid;

  tws_fifo #(.W(tws_pkg::BYTE_W), .D(tws_pkg::FIFO_DEPTH)) i_tws_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // pin synchronisers; only the later two stages feed the filter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
    end
  end

  // a level counts once stages two and three agree
  always_comb begin
    // purely edge driven, so any master rate well below ref_clk works
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
  end

  // bus conditions from filtered levels
  assign scl_rise = scl_f_reg & ~scl_d_reg;
  assign scl_fall = ~scl_f_reg & scl_d_reg;
  assign start_seen = scl_f_reg & scl_d_reg & ~sda_f_reg & sda_d_reg;
  assign stop_seen = scl_f_reg & scl_d_reg & sda_f_reg & ~sda_d_reg;
  // identifier, select bits, not busy
  assign match = (sh_reg[7:4] == tws_pkg::DEV_ID) & (sh_reg[3:1] == sel_reg) & ~busy_reg;
  // empty queue reads as all ones, which the open drain simply leaves released
  assign load_byte = fifo_valid ? fifo_data : tws_pkg::IDLE_BYTE;

  // address register and nonvolatile busy timer
  always_comb begin
    sel_next = sel_reg;
    nv_cnt_next = nv_cnt_reg;
    if (addr_wr) begin
      sel_next = addr_wr_data;
    end
    if (addr_wr | commit_to_nonvolatile_command) begin
      nv_cnt_next = 32'(NV_CYCLES);
    end else if (nv_cnt_reg != 32'h0) begin
      nv_cnt_next = nv_cnt_reg - 32'h1;
    end
    busy_next = (nv_cnt_next != 32'h0);
  end

  // protocol engine: sample on clock rise, change data on clock fall
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    oe_n_next = oe_n_reg;
    dir_next = dir_reg;
    mack_next = mack_reg;
    first_next = first_reg;
    rxd_next = rxd_reg;
    rxv_next = 1'b0;
    rxf_next = 1'b0;
    pop = 1'b0;
    if (stop_seen) begin
      state_next = S_IDLE;
      oe_n_next = 1'b1;
    end else if (start_seen) begin
      state_next = S_ADDR;
      bit_next = 3'h0;
      oe_n_next = 1'b1;
    end else begin
      case (state_reg)
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_f_reg};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == tws_pkg::BIT_LAST) begin
              state_next = (state_reg == S_ADDR) ? S_ADDR_CHK : S_RX_END;
            end
          end
        end
        S_ADDR_CHK: begin
          if (scl_fall) begin
            if (match) begin
              oe_n_next = 1'b0;
              dir_next = sh_reg[0];
              state_next = S_ADDR_ACK;
            end else begin
              state_next = S_IGNORE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 3'h0;
            if (dir_reg) begin
              sh_next = load_byte;
              pop = fifo_valid;
              oe_n_next = load_byte[7];
              state_next = S_TX;
            end else begin
              oe_n_next = 1'b1;
              first_next = 1'b1;
              state_next = S_RX;
            end
          end
        end
        S_RX_END: begin
          if (scl_fall) begin
            rxd_next = sh_reg;
            rxv_next = 1'b1;
            rxf_next = first_reg;
            first_next = 1'b0;
            if (busy_reg) begin
              state_next = S_IGNORE;
            end else begin
              oe_n_next = 1'b0;
              state_next = S_RX_ACK;
            end
          end
        end
        S_RX_ACK: begin
          if (scl_fall) begin
            oe_n_next = 1'b1;
            bit_next = 3'h0;
            state_next = S_RX;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_reg == tws_pkg::BIT_LAST) begin
              oe_n_next = 1'b1;
              state_next = S_TX_ACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b1};
              oe_n_next = sh_reg[6];
              bit_next = bit_reg + 3'h1;
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            mack_next = ~sda_f_reg;
          end
          if (scl_fall) begin
            bit_next = 3'h0;
            if (mack_reg) begin
              sh_next = load_byte;
              pop = fifo_valid;
              oe_n_next = load_byte[7];
              state_next = S_TX;
            end else begin
              state_next = S_IGNORE;
            end
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= S_IDLE;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      dir_reg <= 1'b0;
      mack_reg <= 1'b0;
      first_reg <= 1'b0;
      rxd_reg <= 8'h00;
      rxv_reg <= 1'b0;
      rxf_reg <= 1'b0;
      sel_reg <= tws_pkg::ADDR_SEL_RESET;
      nv_cnt_reg <= 32'h0;
      busy_reg <= 1'b0;
    end else begin
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
      state_reg <= state_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      oe_n_reg <= oe_n_next;
      dir_reg <= dir_next;
      mack_reg <= mack_next;
      first_reg <= first_next;
      rxd_reg <= rxd_next;
      rxv_reg <= rxv_next;
      rxf_reg <= rxf_next;
      sel_reg <= sel_next;
      nv_cnt_reg <= nv_cnt_next;
      busy_reg <= busy_next;
    end
  end

  // open drain: output level is always low, only the enable moves
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = oe_n_reg;
  assign addr_sel = sel_reg;
  assign nv_busy = busy_reg;
  assign rx_data = rxd_reg;
  assign rx_valid = rxv_reg;
  assign rx_first = rxf_reg;
endmodule // tws_slave

// file: test/two_wire_slave_port_bench.sv
// bench joining master and slave ends over one interface
module two_wire_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV = 7000; // longer than an address byte, so the ack slot sees busy
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0, cmd_read = 1'h0, wr_valid = 1'h0, tx_valid = 1'h0;
  logic addr_wr = 1'h0, commit = 1'h0;
  logic [2:0] cmd_addr = 3'h0, addr_wr_data = 3'h0, addr_sel;
  logic [3:0] cmd_count = 4'h0;
  logic [7:0] wr_data = 8'h00, tx_data = 8'h00, m_rx_data, s_rx_data, sh;
  logic cmd_ready, wr_ready, m_rx_valid, done, nack_err, nv_busy, s_rx_valid, rx_first, tx_ready;
  logic [7:0] wq [4], rq [4];
  int fails = 0, total_checks = 0, cyc = 0;
  tws_if bus ();
  tws_master i_tws_master (.ref_clk(ref_clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rx_data(m_rx_data),
    .rx_valid(m_rx_valid), .done(done), .nack_err(nack_err));
  tws_slave #(.NV_CYCLES(NV)) i_tws_slave (.ref_clk(ref_clk), .rst(rst), .bus(bus),
    .addr_wr(addr_wr), .addr_wr_data(addr_wr_data), .commit_to_nonvolatile_command(commit),
    .addr_sel(addr_sel), .nv_busy(nv_busy), .rx_data(s_rx_data), .rx_valid(s_rx_valid),
    .rx_first(rx_first), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  tws_monitor i_tws_monitor (.ref_clk(ref_clk), .rst(rst), .m_sda_oe_n(bus.m_sda_oe_n),
    .s_sda_o(bus.s_sda_o), .s_sda_oe_n(bus.s_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
  always #2 ref_clk = ~ref_clk;
  // hang guard, ceiling a little above the summed transfer times
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'h1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one command through the master; edges read pre-update values, as the design saw them
  task automatic xfer(input logic rd, input logic [2:0] a, input logic [3:0] n,
                      input logic nk, input int srx);
    int k, j, s, b;
    logic sq;
    k = 0;
    j = 0;
    s = 0;
    b = 0;
    sq = 1'h1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_count <= n;
    cmd_valid <= 1'h1;
    wr_data <= wq[0];
    wr_valid <= ~rd && n != 4'h0;
    do begin
      @(posedge ref_clk);
      if (cmd_valid && cmd_ready) cmd_valid <= 1'h0;
      if (wr_valid && wr_ready) begin
        k++;
        wr_data <= wq[k % 4];
        if (k == n) wr_valid <= 1'h0;
      end
      if (m_rx_valid === 1'h1) begin
        chk(m_rx_data === rq[j % 4], "read byte");
        j++;
      end
      if (s_rx_valid === 1'h1) begin
        chk(s_rx_data === wq[s % 4] && rx_first === (s == 0), "written byte");
        s++;
      end
      if (bus.scl === 1'h1 && sq === 1'h0 && b < 8) begin
        sh = {sh[6:0], bus.sda};
        b++;
      end
      sq = bus.scl;
    end while (done !== 1'h1);
    @(posedge ref_clk);
    chk(sh === {tws_pkg::DEV_ID, a, rd}, "address byte on wire");
    chk(nack_err === nk && s == srx && j == ((rd && !nk) ? n : 0), "outcome");
    chk(bus.scl === 1'h1 && bus.sda === 1'h1, "bus idle after stop");
  endtask
  initial begin
    wq = '{8'hA5, 8'h00, 8'h5A, 8'hC3};
    rq = '{8'h81, 8'h7E, 8'h00, 8'h3C};
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    addr_wr_data <= 3'h5;
    addr_wr <= 1'h1;
    @(posedge ref_clk);
    addr_wr <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk(nv_busy === 1'h1 && addr_sel === 3'h5, "select write commits");
    xfer(1'h0, 3'h5, 4'h1, 1'h1, 0);
    while (nv_busy === 1'h1) @(posedge ref_clk);
    xfer(1'h0, 3'h5, 4'h2, 1'h0, 2);
    xfer(1'h0, 3'h2, 4'h1, 1'h1, 0);
    // fill the transmit fifo; the fifth offer must be refused
    for (int i = 0; i < 5; i++) begin
      tx_data <= rq[i % 4];
      tx_valid <= 1'h1;
      @(posedge ref_clk);
      chk(tx_ready === (i < 4), "fifo ready");
    end
    tx_valid <= 1'h0;
    xfer(1'h1, 3'h5, 4'h2, 1'h0, 0);
    rq = '{rq[2], rq[3], 8'hFF, 8'h00};
    xfer(1'h1, 3'h5, 4'h3, 1'h0, 0);
    chk(tx_ready === 1'h1, "fifo drained");
    commit <= 1'h1;
    @(posedge ref_clk);
    commit <= 1'h0;
    xfer(1'h1, 3'h5, 4'h1, 1'h1, 0);
    conclude();
  end
endmodule // two_wire_slave_port_bench

// file: test/tws_monitor.sv
// bus-line checker for the two-wire port, watching both ends on the interface
module tws_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic first_reg, first_next, rw_reg, rw_next;
  logic [3:0] bit_reg, bit_next;
  logic rise, fall, start;
  assign rise = scl & ~scl_q_reg;
  assign fall = ~scl & scl_q_reg;
  assign start = scl & scl_q_reg & sda_q_reg & ~sda;
  // slot position in the nine-bit byte frame, restarted by START
  always_comb begin
    scl_q_next = scl;
    sda_q_next = sda;
    bit_next = bit_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    if (start) begin
      bit_next = 4'h0;
      first_next = 1'h1;
    end else if (rise) begin
      bit_next = (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      if (bit_reg == 4'h8) first_next = 1'h0;
      if (first_reg && bit_reg == 4'h7) rw_next = sda; // direction is last address bit
    end
  end
  // lines idle high out of reset, like the pull-ups
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
      bit_reg <= 4'h0;
      first_reg <= 1'h0;
      rw_reg <= 1'h0;
    end else begin
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      bit_reg <= bit_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rx_slot_s;
    rise && bit_reg != 4'h8 && (first_reg || !rw_reg);
  endsequence
  sequence read_nack_s;
    rise && rw_reg && !first_reg && bit_reg == 4'h8 && sda;
  endsequence
  open_drain_a: assert property (s_sda_o == 1'h0)
    else $error("slave data level not low");
  steady_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
    else $error("slave data changed while clock high");
  stop_release_a: assert property (scl && $rose(sda) |=> s_sda_oe_n [*8])
    else $error("slave drives after stop");
  start_release_a: assert property (start |=> s_sda_oe_n [*8])
    else $error("slave drives after start");
  rx_quiet_a: assert property (rx_slot_s |-> s_sda_oe_n)
    else $error("slave drives a received bit");
  // judged at the fall: the stop setup pulls data low before its own rise
  tx_master_a: assert property (fall && rw_reg && !first_reg && bit_reg != 4'h0 |-> m_sda_oe_n)
    else $error("master drives a read bit");
  master_ack_a: assert property (rise && rw_reg && !first_reg && bit_reg == 4'h8 |-> s_sda_oe_n)
    else $error("slave drives master ack slot");
  nack_release_a: assert property (read_nack_s |=> s_sda_oe_n [*8])
    else $error("slave drives after read nack");
endmodule // tws_monitor
